// ==== common/dtw_consts.svh ====
`ifndef DTW_CONSTS_SVH
`define DTW_CONSTS_SVH

`define DTW_CLK_MHZ 100
// Standard-mode bus figures, in ns
`define DTW_T_LOW_NS 4700
`define DTW_T_HIGH_NS 4000
`define DTW_T_SU_STA_NS 4700
`define DTW_T_HD_STA_NS 4000
`define DTW_T_BUF_NS 4700
// Least times round up to whole clock cycles
`define DTW_LOW_CYC ((`DTW_T_LOW_NS * `DTW_CLK_MHZ + 999) / 1000)
`define DTW_HIGH_CYC ((`DTW_T_HIGH_NS * `DTW_CLK_MHZ + 999) / 1000)
`define DTW_SU_STA_CYC ((`DTW_T_SU_STA_NS * `DTW_CLK_MHZ + 999) / 1000)
`define DTW_HD_STA_CYC ((`DTW_T_HD_STA_NS * `DTW_CLK_MHZ + 999) / 1000)
`define DTW_BUF_CYC ((`DTW_T_BUF_NS * `DTW_CLK_MHZ + 999) / 1000)

`define DTW_ID_MEM 4'ha
`define DTW_ID_REG 4'hd
`define DTW_SLA_PAD 3'h0
`define DTW_AHI_PAD 3'h0
`define DTW_REG_PAD 4'h0
`define DTW_REG_ADDR_MAX 13'h000e
`define DTW_ACK_BIT 4'h8

`endif

// ==== common/dtw_pkg.sv ====
package dtw_pkg;

  typedef enum logic {DTW_MEM, DTW_REG} dtw_tgt_t;

  typedef enum logic [1:0] {DTW_WRITE, DTW_CUR_READ, DTW_SEL_READ} dtw_kind_t;

  // Count is data bytes minus one
  typedef struct packed {
    dtw_tgt_t tgt;
    dtw_kind_t kind;
    logic [12:0] addr;
    logic [7:0] count;
  } dtw_req_t;

endpackage : dtw_pkg

// ==== design/dtw_sync.sv ====
`timescale 1ns/1ps
module dtw_sync #(
  parameter logic RST_VAL = 1'b1
) (
  input wire logic clock_in,
  input wire logic rst_in,
  input wire logic async_in,
  output logic level_out
);

  logic s1_q;
  logic s2_q;
  logic s3_q;

  // Level moves only once the last two stages agree
  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      s1_q <= RST_VAL;
      s2_q <= RST_VAL;
      s3_q <= RST_VAL;
      level_out <= RST_VAL;
    end else begin
      s1_q <= async_in;
      s2_q <= s1_q;
      s3_q <= s2_q;
      if (s2_q == s3_q) begin
        level_out <= s2_q;
      end
    end
  end

endmodule : dtw_sync

// ==== design/dtw_master.sv ====
`timescale 1ns/1ps
`include "dtw_consts.svh"
module dtw_master #(
  parameter int LOW_CYC = `DTW_LOW_CYC,
  parameter int HIGH_CYC = `DTW_HIGH_CYC,
  parameter int SU_STA_CYC = `DTW_SU_STA_CYC,
  parameter int HD_STA_CYC = `DTW_HD_STA_CYC,
  parameter int BUF_CYC = `DTW_BUF_CYC
) (
  input wire logic clock_in,
  input wire logic rst_in,
  input wire logic req_valid_in,
  input wire dtw_pkg::dtw_req_t req_in,
  input wire logic wdata_valid_in,
  input wire logic [7:0] wdata_in,
  input wire logic sda_in,
  output logic req_ready_out,
  output logic wdata_ready_out,
  output logic [7:0] rdata_out,
  output logic rdata_valid_out,
  output logic done_out,
  output logic nack_out,
  output logic scl_out,
  output logic sda_out,
  output logic sda_oe_out
);

  typedef enum logic [3:0] {
    ST_IDLE, ST_START_A, ST_START_B, ST_LOW, ST_HIGH,
    ST_WAIT, ST_RS_LOW, ST_STOP_A, ST_STOP_B, ST_STOP_C
  } dtw_st_t;

  typedef enum logic [2:0] {SQ_SLA, SQ_AHI, SQ_ALO, SQ_WDATA, SQ_RSLA, SQ_RDATA} dtw_seq_t;

  dtw_st_t st_q, st_d;
  dtw_seq_t seq_q, seq_d;
  dtw_pkg::dtw_req_t req_q, req_d;
  logic [7:0] shift_q, shift_d;
  logic [3:0] bit_q, bit_d;
  logic rx_q, rx_d;
  logic [7:0] remain_q, remain_d;
  logic [11:0] cnt_q, cnt_d;
  logic [7:0] rdata_q, rdata_d;
  logic rdv_q, rdv_d;
  logic take_q, take_d;
  logic done_q, done_d;
  logic nack_q, nack_d;
  logic ready_q;
  logic scl_q;
  logic sda_oe_q;
  logic sda_s;

  ////////////////////////////////////////////////////////////////////////////
  // Decoding

  function automatic logic [7:0] sla_byte(dtw_pkg::dtw_tgt_t t, logic rd);
    return {(t == dtw_pkg::DTW_REG) ? `DTW_ID_REG : `DTW_ID_MEM, `DTW_SLA_PAD, rd};
  endfunction : sla_byte

  function automatic logic [11:0] dur(dtw_st_t s);
    case (s)
      ST_LOW, ST_RS_LOW, ST_STOP_A: return 12'(LOW_CYC - 1);
      ST_HIGH, ST_STOP_B: return 12'(HIGH_CYC - 1);
      ST_START_A: return 12'(SU_STA_CYC - 1);
      ST_START_B: return 12'(HD_STA_CYC - 1);
      ST_STOP_C: return 12'(BUF_CYC - 1);
      default: return 12'h000;
    endcase
  endfunction : dur

  // Pull-down request for the data line
  function automatic logic sda_pull(dtw_st_t s, logic [7:0] sh, logic [3:0] b, logic r, logic l);
    if (s == ST_START_B || s == ST_STOP_A || s == ST_STOP_B) begin
      return 1'b1;
    end
    if (s == ST_LOW || s == ST_HIGH) begin
      return (b == `DTW_ACK_BIT) ? (r && !l) : (!r && !sh[7]);
    end
    return 1'b0;
  endfunction : sda_pull

  wire logic phase_end = (cnt_q == 12'h000);
  wire logic bit_end = (st_q == ST_HIGH) && phase_end;
  wire logic ack_slot = (bit_q == `DTW_ACK_BIT);
  wire logic last = (remain_q == 8'h00);
  wire logic take = req_valid_in && ready_q;
  wire logic req_bad = (req_in.tgt == dtw_pkg::DTW_REG) && (req_in.addr > `DTW_REG_ADDR_MAX);
  wire logic kind_cur = (req_q.kind == dtw_pkg::DTW_CUR_READ);
  wire logic kind_sel = (req_q.kind == dtw_pkg::DTW_SEL_READ);
  wire logic [7:0] ahi_byte = {`DTW_AHI_PAD, req_q.addr[12:8]};
  wire logic [7:0] alo_byte = (req_q.tgt == dtw_pkg::DTW_REG) ? {`DTW_REG_PAD, req_q.addr[3:0]} : req_q.addr[7:0];
  wire logic scl_d = (st_d == ST_IDLE) || (st_d == ST_START_A) || (st_d == ST_START_B) ||
                     (st_d == ST_HIGH) || (st_d == ST_STOP_B) || (st_d == ST_STOP_C);
  wire logic sda_oe_d = sda_pull(st_d, shift_d, bit_d, rx_d, remain_d == 8'h00);

  dtw_sync #(
    .RST_VAL(1'b1)
  ) u_sda_sync (
    .clock_in(clock_in),
    .rst_in(rst_in),
    .async_in(sda_in),
    .level_out(sda_s)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Sequencing

  always_comb begin
    st_d = st_q;
    seq_d = seq_q;
    req_d = req_q;
    shift_d = shift_q;
    bit_d = bit_q;
    rx_d = rx_q;
    remain_d = remain_q;
    rdata_d = rdata_q;
    cnt_d = phase_end ? cnt_q : cnt_q - 12'h001;
    rdv_d = 1'b0;
    take_d = 1'b0;
    done_d = 1'b0;
    nack_d = 1'b0;
    case (st_q)
      ST_IDLE: begin
        if (take && req_bad) begin
          // Device would refuse it anyway; spare the bus
          nack_d = 1'b1;
        end else if (take) begin
          req_d = req_in;
          seq_d = SQ_SLA;
          shift_d = sla_byte(req_in.tgt, req_in.kind == dtw_pkg::DTW_CUR_READ);
          rx_d = 1'b0;
          bit_d = 4'h0;
          remain_d = req_in.count;
          st_d = ST_START_A;
        end
      end
      ST_START_A: if (phase_end) st_d = ST_START_B;
      ST_START_B: if (phase_end) st_d = ST_LOW;
      ST_LOW: if (phase_end) st_d = ST_HIGH;
      ST_HIGH: begin
        if (phase_end && !ack_slot) begin
          shift_d = {shift_q[6:0], sda_s};
          bit_d = bit_q + 4'h1;
          st_d = ST_LOW;
        end else if (phase_end) begin
          bit_d = 4'h0;
          st_d = ST_LOW;
          if (rx_q) begin
            rdv_d = 1'b1;
            rdata_d = shift_q;
            if (last) begin
              st_d = ST_STOP_A;
            end else begin
              remain_d = remain_q - 8'h01;
            end
          end else if (sda_s) begin
            nack_d = 1'b1;
            st_d = ST_STOP_A;
          end else begin
            case (seq_q)
              SQ_SLA: begin
                if (kind_cur) begin
                  seq_d = SQ_RDATA;
                  rx_d = 1'b1;
                end else if (req_q.tgt == dtw_pkg::DTW_MEM) begin
                  seq_d = SQ_AHI;
                  shift_d = ahi_byte;
                end else begin
                  seq_d = SQ_ALO;
                  shift_d = alo_byte;
                end
              end
              SQ_AHI: begin
                seq_d = SQ_ALO;
                shift_d = alo_byte;
              end
              SQ_ALO: begin
                if (kind_sel) begin
                  seq_d = SQ_RSLA;
                  shift_d = sla_byte(req_q.tgt, 1'b1);
                  st_d = ST_RS_LOW;
                end else begin
                  seq_d = SQ_WDATA;
                  st_d = ST_WAIT;
                end
              end
              SQ_WDATA: begin
                if (last) begin
                  st_d = ST_STOP_A;
                end else begin
                  remain_d = remain_q - 8'h01;
                  st_d = ST_WAIT;
                end
              end
              SQ_RSLA: begin
                seq_d = SQ_RDATA;
                rx_d = 1'b1;
              end
              default: st_d = ST_STOP_A;
            endcase
          end
        end
      end
      ST_WAIT: begin
        // Clock held low until the user has a byte
        if (wdata_valid_in) begin
          shift_d = wdata_in;
          take_d = 1'b1;
          st_d = ST_LOW;
        end
      end
      ST_RS_LOW: if (phase_end) st_d = ST_START_A;
      ST_STOP_A: if (phase_end) st_d = ST_STOP_B;
      ST_STOP_B: if (phase_end) st_d = ST_STOP_C;
      ST_STOP_C: begin
        if (phase_end) begin
          st_d = ST_IDLE;
          done_d = 1'b1;
        end
      end
      default: st_d = ST_IDLE;
    endcase
    if (st_d != st_q) begin
      cnt_d = dur(st_d);
    end
  end

  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      st_q <= ST_IDLE;
      seq_q <= SQ_SLA;
      req_q <= '0;
      shift_q <= 8'h00;
      bit_q <= 4'h0;
      rx_q <= 1'b0;
      remain_q <= 8'h00;
      cnt_q <= 12'h000;
      rdata_q <= 8'h00;
      rdv_q <= 1'b0;
      take_q <= 1'b0;
      done_q <= 1'b0;
      nack_q <= 1'b0;
      ready_q <= 1'b1;
      scl_q <= 1'b1;
      sda_oe_q <= 1'b0;
    end else begin
      st_q <= st_d;
      seq_q <= seq_d;
      req_q <= req_d;
      shift_q <= shift_d;
      bit_q <= bit_d;
      rx_q <= rx_d;
      remain_q <= remain_d;
      cnt_q <= cnt_d;
      rdata_q <= rdata_d;
      rdv_q <= rdv_d;
      take_q <= take_d;
      done_q <= done_d;
      nack_q <= nack_d;
      ready_q <= (st_d == ST_IDLE);
      scl_q <= scl_d;
      sda_oe_q <= sda_oe_d;
    end
  end

  assign req_ready_out = ready_q;
  assign wdata_ready_out = take_q;
  assign rdata_out = rdata_q;
  assign rdata_valid_out = rdv_q;
  assign done_out = done_q;
  assign nack_out = nack_q;
  assign scl_out = scl_q;
  assign sda_out = 1'b0;
  assign sda_oe_out = sda_oe_q;

  ////////////////////////////////////////////////////////////////////////////
  // Checks

  default clocking cb @(posedge clock_in);
  endclocking
  default disable iff (rst_in);

  sequence s_tx_nack;
    bit_end && ack_slot && !rx_q && sda_s;
  endsequence

  sequence s_rx_last;
    bit_end && ack_slot && rx_q && last;
  endsequence

  sequence s_alo_sel;
    bit_end && ack_slot && !rx_q && !sda_s && seq_q == SQ_ALO && kind_sel;
  endsequence

  a_sda_steady_high: assert property (
    (st_q == ST_HIGH && $past(st_q) == ST_HIGH) |-> $stable(sda_oe_out))
    else $error("data line moved while clock high");

  a_ack_slot_release: assert property (
    (scl_out && st_q == ST_HIGH && ack_slot && !rx_q) |-> !sda_oe_out)
    else $error("data line held in device ack slot");

  a_nack_then_stop: assert property (
    s_tx_nack |=> (st_q == ST_STOP_A && nack_out) ##[1:1000] (st_q == ST_STOP_B && scl_out && sda_oe_out))
    else $error("device nack not followed by stop");

  a_read_ack_level: assert property (
    (st_q == ST_HIGH && ack_slot && rx_q) |-> sda_oe_out == !last)
    else $error("wrong acknowledge for read byte");

  a_msb_first_out: assert property (
    (st_q == ST_HIGH && !ack_slot && !rx_q) |-> sda_oe_out == !shift_q[7])
    else $error("bit on line is not shifter msb");

  a_shift_order: assert property (
    (bit_end && !ack_slot) |=> shift_q == {$past(shift_q[6:0]), $past(sda_s)})
    else $error("shifter not moving msb first");

  a_slave_byte_form: assert property (
    (st_q == ST_LOW && bit_q == 4'h0 && (seq_q == SQ_SLA || seq_q == SQ_RSLA))
    |-> shift_q == sla_byte(req_q.tgt, seq_q == SQ_RSLA || kind_cur))
    else $error("slave address byte malformed");

  a_upper_addr_pad: assert property (
    (st_q == ST_LOW && bit_q == 4'h0 && seq_q == SQ_AHI) |-> shift_q == {3'h0, req_q.addr[12:8]})
    else $error("upper address byte malformed");

  a_read_end_stop: assert property (
    s_rx_last |=> (st_q == ST_STOP_A && rdata_valid_out) ##1 (sda_oe_out && !scl_out))
    else $error("last read byte not closed by stop");

  a_sel_restart: assert property (
    s_alo_sel |=> (st_q == ST_RS_LOW && !sda_oe_out) ##[1:1000] (st_q == ST_START_A && scl_out && !sda_oe_out))
    else $error("selective read lacks repeated start");

  a_addr_before_data: assert property (
    (seq_q == SQ_WDATA && $past(seq_q) != SQ_WDATA) |-> $past(seq_q) == SQ_ALO)
    else $error("write data before address");

  a_reg_addr_nibble: assert property (
    (st_q == ST_LOW && bit_q == 4'h0 && seq_q == SQ_ALO && req_q.tgt == dtw_pkg::DTW_REG)
    |-> shift_q[7:4] == 4'h0 && shift_q <= 8'h0e)
    else $error("register address byte out of form");

  a_start_stop_edges: assert property (
    (scl_out && $past(scl_out) && $changed(sda_oe_out))
    |-> (sda_oe_out && st_q == ST_START_B) || (!sda_oe_out && st_q == ST_STOP_C))
    else $error("data edge under high clock outside start or stop");

endmodule : dtw_master

// ==== tb/dtw_dev_model.sv ====
`timescale 1ns/1ps
module dtw_dev_model (
  input wire logic clock_in,
  input wire logic rst_in,
  input wire logic scl_in,
  input wire logic sda_in,
  input wire logic nack_data_in,
  output logic sda_oe_out,
  output int bad_out
);
  typedef enum logic [2:0] {DTW_DM_IDLE, DTW_DM_SLA, DTW_DM_AHI, DTW_DM_ALO, DTW_DM_WR, DTW_DM_RD} dtw_dm_t;
  dtw_dm_t st_q = DTW_DM_IDLE;
  dtw_dm_t nx_q = DTW_DM_IDLE;
  dtw_dm_t nst_v;
  logic [7:0] mem_q [8192];
  logic [7:0] regs_q [15];
  logic [12:0] ma_q = '0;
  logic [3:0] ra_q = '0;
  logic [7:0] sh_q = '0;
  logic [7:0] so_q = '0;
  logic [7:0] b_v;
  logic [3:0] bitc_q = '0;
  logic scl_q = 1'b1;
  logic sda_q = 1'b1;
  logic tgt_q = 1'b0;
  logic mack_q = 1'b0;
  logic oe_q = 1'b0;
  logic ok_v;
  logic inc_v;
  logic bad_v;
  int bad_q = 0;
  // Edges seen one cycle late, so a data change on the clock's falling edge never looks like a start
  wire logic start_w = scl_q && scl_in && sda_q && !sda_in;
  wire logic stop_w = scl_q && scl_in && !sda_q && sda_in;
  wire logic rise_w = !scl_q && scl_in;
  wire logic fall_w = scl_q && !scl_in;
  assign sda_oe_out = oe_q;
  assign bad_out = bad_q;

  initial begin
    for (int i = 0; i < 8192; i++) begin
      mem_q[i] = 8'(i) ^ 8'(i >> 8);
    end
    for (int j = 0; j < 15; j++) begin
      regs_q[j] = 8'(j * 17 + 3);
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  always @(posedge clock_in) begin
    inc_v = 1'b0;
    bad_v = 1'b0;
    scl_q <= scl_in;
    sda_q <= sda_in;
    if (rst_in) begin
      st_q <= DTW_DM_IDLE;
      oe_q <= 1'b0;
      bitc_q <= 4'h0;
      ma_q <= 13'h0000;
      ra_q <= 4'h0;
    end else if (start_w || stop_w) begin
      // Mid-byte or mid-read conditions are master faults
      bad_v = st_q == DTW_DM_RD || (st_q != DTW_DM_IDLE && bitc_q != 4'h0);
      st_q <= start_w ? DTW_DM_SLA : DTW_DM_IDLE;
      // Clock fall closing a start carries no bit; all ones wraps to zero there
      bitc_q <= start_w ? 4'hf : 4'h0;
      oe_q <= 1'b0;
    end else if (st_q != DTW_DM_IDLE && rise_w) begin
      if (bitc_q < 4'h8) begin
        sh_q <= {sh_q[6:0], sda_in};
      end else begin
        mack_q <= !sda_in;
      end
    end else if (st_q != DTW_DM_IDLE && fall_w && bitc_q == 4'h8) begin
      bitc_q <= 4'h0;
      nst_v = (st_q == DTW_DM_RD) ? (mack_q ? DTW_DM_RD : DTW_DM_IDLE) : nx_q;
      st_q <= nst_v;
      b_v = tgt_q ? regs_q[ra_q] : mem_q[ma_q];
      oe_q <= (nst_v == DTW_DM_RD) && !b_v[7];
      so_q <= {b_v[6:0], 1'b1};
      inc_v = nst_v == DTW_DM_RD;
    end else if (st_q != DTW_DM_IDLE && fall_w && bitc_q == 4'h7) begin
      bitc_q <= 4'h8;
      ok_v = 1'b1;
      case (st_q)
        DTW_DM_SLA: begin
          ok_v = (sh_q[7:4] == 4'ha || sh_q[7:4] == 4'hd) && sh_q[3:1] == 3'h0;
          tgt_q <= sh_q[7:4] == 4'hd;
          nx_q <= sh_q[0] ? DTW_DM_RD : (sh_q[7:4] == 4'hd ? DTW_DM_ALO : DTW_DM_AHI);
        end
        DTW_DM_AHI: begin
          ma_q[12:8] <= sh_q[4:0];
          bad_v = sh_q[7:5] != 3'h0;
          nx_q <= DTW_DM_ALO;
        end
        DTW_DM_ALO: begin
          ok_v = !tgt_q || sh_q <= 8'h0e;
          nx_q <= DTW_DM_WR;
          if (tgt_q && ok_v) begin
            ra_q <= sh_q[3:0];
          end else if (!tgt_q) begin
            ma_q[7:0] <= sh_q;
          end
        end
        DTW_DM_WR: begin
          // Array write lands before the ack, even when that ack is refused
          ok_v = !nack_data_in;
          inc_v = 1'b1;
          if (tgt_q) begin
            regs_q[ra_q] <= sh_q;
          end else begin
            mem_q[ma_q] <= sh_q;
          end
        end
        default: ok_v = 1'b0;
      endcase
      oe_q <= ok_v;
      if (!ok_v && st_q != DTW_DM_RD) begin
        nx_q <= DTW_DM_IDLE;
      end
    end else if (st_q != DTW_DM_IDLE && fall_w) begin
      bitc_q <= bitc_q + 4'h1;
      if (st_q == DTW_DM_RD) begin
        oe_q <= !so_q[7];
        so_q <= {so_q[6:0], 1'b1};
      end
    end
    if (inc_v && tgt_q) begin
      ra_q <= (ra_q == 4'he) ? 4'h0 : ra_q + 4'h1;
    end
    if (inc_v && !tgt_q) begin
      ma_q <= ma_q + 13'h0001;
    end
    if (bad_v) begin
      bad_q <= bad_q + 1;
    end
  end
endmodule : dtw_dev_model

// ==== tb/dual_target_two_wire_slave_test.sv ====
`timescale 1ns/1ps
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin num_errors++; $display("unexpected at %0t: %h vs %h", $time, g, e); end end
module dual_target_two_wire_slave_test;
  logic clock_in = 1'b0;
  logic rst_in = 1'b1;
  logic req_valid_in = 1'b0;
  logic wdata_valid_in = 1'b0;
  logic nack_data = 1'b0;
  dtw_pkg::dtw_req_t req_in = '0;
  logic [7:0] wdata_in = '0;
  logic [7:0] rdata_out;
  logic [7:0] ev;
  logic req_ready_out, wdata_ready_out, rdata_valid_out, done_out, nack_out, scl_out, sda_out, sda_oe_out, dev_oe;
  wire logic sda_wire = !(sda_oe_out || dev_oe);
  int num_errors = 0;
  int compares = 0;
  int dev_bad;
  logic [7:0] e_mem [8192];
  logic [7:0] e_reg [15];
  logic [12:0] e_ma = '0;
  logic [3:0] e_ra = '0;

  always #5 clock_in = ~clock_in;

  // Short bus phases keep the run small
  dtw_master #(.LOW_CYC(8), .HIGH_CYC(8), .SU_STA_CYC(8), .HD_STA_CYC(8), .BUF_CYC(8)) dut (
    .clock_in(clock_in), .rst_in(rst_in), .req_valid_in(req_valid_in), .req_in(req_in),
    .wdata_valid_in(wdata_valid_in), .wdata_in(wdata_in), .sda_in(sda_wire), .req_ready_out(req_ready_out),
    .wdata_ready_out(wdata_ready_out), .rdata_out(rdata_out), .rdata_valid_out(rdata_valid_out),
    .done_out(done_out), .nack_out(nack_out), .scl_out(scl_out), .sda_out(sda_out), .sda_oe_out(sda_oe_out));

  dtw_dev_model dev (.clock_in(clock_in), .rst_in(rst_in), .scl_in(scl_out), .sda_in(sda_wire),
    .nack_data_in(nack_data), .sda_oe_out(dev_oe), .bad_out(dev_bad));

  ////////////////////////////////////////////////////////////////////////////////
  function automatic logic [7:0] e_rd(input int t);
    logic [7:0] v;
    v = t ? e_reg[e_ra] : e_mem[e_ma];
    if (t) e_ra = (e_ra == 4'he) ? 4'h0 : e_ra + 4'h1;
    else e_ma = e_ma + 13'h0001;
    return v;
  endfunction : e_rd

  function automatic void e_wr(input int t, input logic [7:0] b);
    if (t) e_reg[e_ra] = b;
    else e_mem[e_ma] = b;
    void'(e_rd(t));
  endfunction : e_wr

  task automatic conclude();
    $display("errors %0d compares %0d", num_errors, compares);
    if (num_errors == 0 && compares > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : conclude

  task automatic run(input int t, input int k, input logic [12:0] a, input int n, input int rf, input int nke);
    dtw_pkg::dtw_req_t r;
    logic [7:0] d [$];
    int cyc, w, rc, nk;
    r.tgt = dtw_pkg::dtw_tgt_t'(t);
    r.kind = dtw_pkg::dtw_kind_t'(k);
    r.addr = a;
    r.count = 8'(n - 1);
    for (int i = 0; i <= n; i++) d.push_back(8'($urandom));
    if (!rf && k != 1 && t) e_ra = a[3:0];
    if (!rf && k != 1 && !t) e_ma = a;
    req_valid_in = 1'b1;
    req_in = r;
    wdata_in = d[0];
    wdata_valid_in = (k == 0);
    for (cyc = 0; cyc < 100 && req_ready_out !== 1'b1; cyc++) begin
      @(posedge clock_in); #1;
    end
    if (cyc == 100) begin
      num_errors++;
      conclude();
    end
    @(posedge clock_in); #1;
    req_valid_in = 1'b0;
    w = 0; rc = 0; nk = 0;
    for (cyc = 0; cyc < 20000; cyc++) begin
      if (nack_out === 1'b1) nk++;
      if (wdata_ready_out === 1'b1) begin
        e_wr(t, d[w]);
        w++;
        wdata_in = d[w];
        if (w == n) wdata_valid_in = 1'b0;
      end
      if (rdata_valid_out === 1'b1) begin
        ev = e_rd(t);
        `CHK(rdata_out, ev)
        rc++;
      end
      if (done_out === 1'b1 || (rf && nk > 0)) break;
      @(posedge clock_in); #1;
    end
    if (cyc == 20000) begin
      num_errors++;
      conclude();
    end
    `CHK(nk, rf + nke)
    if (k == 0 && !rf) `CHK(w, nke ? 1 : n)
    if (k != 0 && !rf) `CHK(rc, n)
    if (rf) `CHK(scl_out, 1'b1)
    if (!rf) `CHK(req_ready_out, 1'b1)
  endtask : run

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    int t;
    void'($urandom(48));
    for (int i = 0; i < 8192; i++) e_mem[i] = 8'(i) ^ 8'(i >> 8);
    for (int j = 0; j < 15; j++) e_reg[j] = 8'(j * 17 + 3);
    repeat (2) @(posedge clock_in);
    #1 rst_in = 1'b0;
    `CHK(scl_out, 1'b1)
    `CHK(sda_oe_out, 1'b0)
    `CHK(sda_out, 1'b0)
    run(0, 1, 13'h0000, 2, 0, 0);
    run(0, 0, 13'h1ffe, 4, 0, 0);
    run(0, 2, 13'h1ffe, 4, 0, 0);
    run(1, 0, 13'h000d, 3, 0, 0);
    run(0, 1, 13'h0000, 2, 0, 0);
    run(1, 2, 13'h000e, 2, 0, 0);
    run(1, 1, 13'h0000, 2, 0, 0);
    run(1, 0, 13'h000f, 1, 1, 0);
    run(1, 2, 13'h00ff, 1, 1, 0);
    nack_data = 1'b1;
    run(0, 0, 13'h0100, 3, 0, 1);
    nack_data = 1'b0;
    run(0, 1, 13'h0000, 2, 0, 0);
    for (int i = 0; i < 24; i++) begin
      t = $urandom_range(0, 1);
      run(t, $urandom_range(0, 2), t ? 13'($urandom_range(0, 14)) : 13'($urandom), $urandom_range(1, 4), 0, 0);
    end
    `CHK(dev_bad, 0)
    conclude();
  end
endmodule : dual_target_two_wire_slave_test
